// ### verilog/sdx_pkg.sv
// package for the sd host auxiliary configuration bank
// assumes a 32-bit ahb-lite register bus and a card clock link domain
package sdx_pkg;
  // ===========================================================
  // register byte offsets
  localparam logic [7:0] SDX_OFF_BOOT_TIMEOUT = 8'h00;
  localparam logic [7:0] SDX_OFF_DEBUG_SEL = 8'h04;
  localparam logic [7:0] SDX_OFF_FIFO_THRESH = 8'h08;
  localparam logic [7:0] SDX_OFF_FIFO_EN = 8'h0c;
  localparam logic [7:0] SDX_OFF_STEP_DELAY = 8'h10;
  localparam logic [7:0] SDX_OFF_STEPS_SDR = 8'h14;
  localparam logic [7:0] SDX_OFF_STEPS_DDR = 8'h18;
  localparam logic [7:0] SDX_OFF_SPI_INT = 8'h1c;
  localparam logic [7:0] SDX_OFF_SLOT_VER = 8'h20;
  localparam logic [7:0] SDX_OFF_CTRL = 8'h24;
  localparam logic [7:0] SDX_OFF_STATUS = 8'h28;
  // ===========================================================
  // field positions and reset values
  localparam int SDX_CTRL_MODE_LSB = 16;
  localparam int SDX_STAT_TIMEOUT_BIT = 0;
  localparam int SDX_STAT_BOOTING_BIT = 1;
  localparam int SDX_STAT_DMA_BIT = 2;
  localparam logic [31:0] SDX_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] SDX_RST_VENDOR = 8'h00;
  localparam logic [7:0] SDX_RST_SPEC = 8'h00;
  localparam logic [5:0] SDX_MAX_STEPS = 6'h28;
  // ===========================================================
  // bus speed mode codes
  typedef enum logic [2:0] {
    SDX_SDR12 = 3'b000,
    SDX_SDR25 = 3'b001,
    SDX_SDR50 = 3'b010,
    SDX_SDR104 = 3'b011,
    SDX_DDR50 = 3'b100
  } sdx_mode_t;
  // boot timer states (link domain)
  typedef enum logic [1:0] {
    SDX_B_IDLE = 2'b00,
    SDX_B_COUNT = 2'b01,
    SDX_B_EXPIRED = 2'b10
  } sdx_boot_t;
endpackage : sdx_pkg

// ### verilog/sdx_aux_cfg.sv
// auxiliary configuration bank of an sd/emmc host controller
// assumes ahb-lite slave on i_clk; card clock i_card_clk is free running
// during boot; fifo level and slot signals come from the card clock side
module sdx_aux_cfg
  import sdx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_card_clk,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_boot_active,
  input wire logic i_card_read,
  input wire logic [3:0] i_fifo_words,
  input wire logic [7:0] i_slot_irq,
  input wire logic [7:0] i_slot_wakeup,
  output logic o_boot_timeout,
  output logic o_debug_bus_select,
  output logic o_ext_fifo_enable,
  output logic o_dma_req,
  output logic [7:0] o_spi_interrupt_any_select,
  output logic [5:0] o_active_steps,
  output logic [15:0] o_sample_delay_ps
);
  // ===========================================================
  // register state
  logic [31:0] boot_timeout_count, next_boot_timeout_count;
  logic debug_bus_select, next_debug_bus_select;
  logic [2:0] read_threshold_words, next_read_threshold_words;
  logic ext_fifo_enable, next_ext_fifo_enable;
  logic [2:0] sample_delay_per_step, next_sample_delay_per_step;
  logic [5:0] steps_sdr, next_steps_sdr;
  logic [5:0] steps_ddr, next_steps_ddr;
  logic [7:0] spi_any, next_spi_any;
  logic [7:0] vendor_ver, next_vendor_ver;
  logic [7:0] host_spec_version, next_host_spec_version;
  logic [2:0] bus_speed_mode, next_bus_speed_mode;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] hrdata, next_hrdata;
  // synchronised inputs from the card side
  logic [7:0] slot_s1, slot_s2;
  logic [3:0] lvl_s1, lvl_s2;
  logic rd_s1, rd_s2, to_s1, to_s2, bt_s1, bt_s2;
  // boot timer flags, launched on the card clock
  logic boot_flag, next_boot_flag;
  logic boot_on;
  // ===========================================================
  // bus slave
  logic addr_ok;
  logic [7:0] a;
  logic [31:0] rd_word;
  logic [4:0] st_base;
  logic [5:0] active_steps;
  logic dma_req;
  // 40 steps of 1100 ps need 16 bits
  logic [15:0] delay_ps;

  assign a = i_haddr[7:0];

  // per-step delay in ps for each code
  function automatic logic [10:0] step_ps(input logic [2:0] c);
    case (c)
      3'h0: step_ps = 11'd200;
      3'h1: step_ps = 11'd400;
      3'h2: step_ps = 11'd400;
      3'h3: step_ps = 11'd600;
      3'h4: step_ps = 11'd700;
      3'h5: step_ps = 11'd900;
      3'h6: step_ps = 11'd900;
      default: step_ps = 11'd1100;
    endcase
  endfunction : step_ps

  always_comb begin
    active_steps = (bus_speed_mode == SDX_DDR50) ? steps_ddr : steps_sdr;
    delay_ps = 16'(active_steps) * 16'(step_ps(sample_delay_per_step));
    // read with fifo in path: hold dma until level reaches threshold
    if (ext_fifo_enable && rd_s2) begin
      dma_req = (lvl_s2 >= {1'b0, read_threshold_words});
    end else begin
      dma_req = 1'b1;
    end
    st_base = 5'h0;
    rd_word = SDX_RST_WORD;
    case (a)
      SDX_OFF_BOOT_TIMEOUT: rd_word = boot_timeout_count;
      SDX_OFF_DEBUG_SEL: rd_word = {31'h0, debug_bus_select};
      SDX_OFF_FIFO_THRESH: rd_word = {29'h0, read_threshold_words};
      SDX_OFF_FIFO_EN: rd_word = {31'h0, ext_fifo_enable};
      SDX_OFF_STEP_DELAY: rd_word = {29'h0, sample_delay_per_step};
      SDX_OFF_STEPS_SDR: rd_word = {26'h0, steps_sdr};
      SDX_OFF_STEPS_DDR: rd_word = {26'h0, steps_ddr};
      SDX_OFF_SPI_INT: rd_word = {24'h0, spi_any};
      SDX_OFF_SLOT_VER: rd_word = {vendor_ver, host_spec_version,
                                   8'h00, slot_s2};
      SDX_OFF_CTRL: rd_word = {13'h0, bus_speed_mode, 16'h0};
      SDX_OFF_STATUS: rd_word = {29'h0, dma_req, bt_s2, to_s2};
      default: rd_word = SDX_RST_WORD;
    endcase
    addr_ok = i_hsel && i_hready && i_htrans[1];
    next_wr_pend = addr_ok && i_hwrite;
    next_wr_addr = addr_ok ? a : wr_addr;
    next_hrdata = (addr_ok && !i_hwrite) ? rd_word : hrdata;
    next_boot_timeout_count = boot_timeout_count;
    next_debug_bus_select = debug_bus_select;
    next_read_threshold_words = read_threshold_words;
    next_ext_fifo_enable = ext_fifo_enable;
    next_sample_delay_per_step = sample_delay_per_step;
    next_steps_sdr = steps_sdr;
    next_steps_ddr = steps_ddr;
    next_spi_any = spi_any;
    next_vendor_ver = vendor_ver;
    next_host_spec_version = host_spec_version;
    next_bus_speed_mode = bus_speed_mode;
    if (wr_pend) begin
      case (wr_addr)
        SDX_OFF_BOOT_TIMEOUT: next_boot_timeout_count = i_hwdata;
        SDX_OFF_DEBUG_SEL: next_debug_bus_select = i_hwdata[0];
        SDX_OFF_FIFO_THRESH: next_read_threshold_words = i_hwdata[2:0];
        SDX_OFF_FIFO_EN: next_ext_fifo_enable = i_hwdata[0];
        SDX_OFF_STEP_DELAY: next_sample_delay_per_step = i_hwdata[2:0];
        SDX_OFF_STEPS_SDR: next_steps_sdr = (i_hwdata[5:0] > SDX_MAX_STEPS)
                                            ? SDX_MAX_STEPS : i_hwdata[5:0];
        SDX_OFF_STEPS_DDR: next_steps_ddr = (i_hwdata[5:0] > SDX_MAX_STEPS)
                                            ? SDX_MAX_STEPS : i_hwdata[5:0];
        SDX_OFF_SPI_INT: next_spi_any = i_hwdata[7:0];
        SDX_OFF_SLOT_VER: begin
          next_vendor_ver = i_hwdata[31:24];
          next_host_spec_version = i_hwdata[23:16];
        end
        SDX_OFF_CTRL: next_bus_speed_mode =
          (i_hwdata[18:16] > SDX_DDR50) ? bus_speed_mode
                                         : i_hwdata[18:16];
        default: st_base = 5'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_timeout_count <= SDX_RST_WORD;
      debug_bus_select <= 1'b0;
      read_threshold_words <= 3'h0;
      ext_fifo_enable <= 1'b0;
      sample_delay_per_step <= 3'h0;
      steps_sdr <= 6'h00;
      steps_ddr <= 6'h00;
      spi_any <= 8'h00;
      vendor_ver <= SDX_RST_VENDOR;
      host_spec_version <= SDX_RST_SPEC;
      bus_speed_mode <= SDX_SDR12;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= SDX_RST_WORD;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= SDX_RST_WORD;
      o_debug_bus_select <= 1'b0;
      o_ext_fifo_enable <= 1'b0;
      o_dma_req <= 1'b0;
      o_spi_interrupt_any_select <= 8'h00;
      o_active_steps <= 6'h00;
      o_sample_delay_ps <= 16'h0000;
      o_boot_timeout <= 1'b0;
    end else begin
      boot_timeout_count <= next_boot_timeout_count;
      debug_bus_select <= next_debug_bus_select;
      read_threshold_words <= next_read_threshold_words;
      ext_fifo_enable <= next_ext_fifo_enable;
      sample_delay_per_step <= next_sample_delay_per_step;
      steps_sdr <= next_steps_sdr;
      steps_ddr <= next_steps_ddr;
      spi_any <= next_spi_any;
      vendor_ver <= next_vendor_ver;
      host_spec_version <= next_host_spec_version;
      bus_speed_mode <= next_bus_speed_mode;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= next_hrdata;
      o_debug_bus_select <= next_debug_bus_select;
      o_ext_fifo_enable <= next_ext_fifo_enable;
      o_dma_req <= dma_req;
      o_spi_interrupt_any_select <= next_spi_any;
      o_active_steps <= active_steps;
      o_sample_delay_ps <= delay_ps;
      o_boot_timeout <= to_s2;
    end
  end

  // ===========================================================
  // synchronisers into i_clk
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_s1 <= 8'h00;
      slot_s2 <= 8'h00;
      lvl_s1 <= 4'h0;
      lvl_s2 <= 4'h0;
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      to_s1 <= 1'b0;
      to_s2 <= 1'b0;
      bt_s1 <= 1'b0;
      bt_s2 <= 1'b0;
    end else begin
      slot_s1 <= i_slot_irq | i_slot_wakeup;
      slot_s2 <= slot_s1;
      lvl_s1 <= i_fifo_words;
      lvl_s2 <= lvl_s1;
      rd_s1 <= i_card_read;
      rd_s2 <= rd_s1;
      to_s1 <= boot_flag;
      to_s2 <= to_s1;
      bt_s1 <= boot_on;
      bt_s2 <= bt_s1;
    end
  end

  // ===========================================================
  // boot timer on the card clock
  logic [31:0] limit_s1, limit_s2;
  logic act_s1, act_s2;
  logic [31:0] boot_cnt, next_boot_cnt;
  sdx_boot_t boot_st, next_boot_st;

  assign boot_on = (boot_st == SDX_B_COUNT);

  always_comb begin
    next_boot_st = boot_st;
    next_boot_cnt = boot_cnt;
    next_boot_flag = boot_flag;
    case (boot_st)
      SDX_B_IDLE: begin
        next_boot_cnt = 32'h0;
        if (act_s2) begin
          next_boot_st = SDX_B_COUNT;
          next_boot_flag = 1'b0;
        end
      end
      SDX_B_COUNT: begin
        if (!act_s2) begin
          next_boot_st = SDX_B_IDLE;
          next_boot_cnt = 32'h0;
        end else if (boot_cnt + 32'h1 >= limit_s2) begin
          next_boot_st = SDX_B_EXPIRED;
          next_boot_flag = 1'b1;
        end else begin
          next_boot_cnt = boot_cnt + 32'h1;
        end
      end
      SDX_B_EXPIRED: begin
        if (!act_s2) begin
          // boot over: the flag must not outlive it
          next_boot_st = SDX_B_IDLE;
          next_boot_flag = 1'b0;
        end
      end
      default: next_boot_st = SDX_B_IDLE;
    endcase
  end

  always_ff @(posedge i_card_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      limit_s1 <= SDX_RST_WORD;
      limit_s2 <= SDX_RST_WORD;
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
      boot_cnt <= 32'h0;
      boot_st <= SDX_B_IDLE;
      boot_flag <= 1'b0;
    end else begin
      // count is static while a boot runs, so a level crossing suffices
      limit_s1 <= boot_timeout_count;
      limit_s2 <= limit_s1;
      act_s1 <= i_boot_active;
      act_s2 <= act_s1;
      boot_cnt <= next_boot_cnt;
      boot_st <= next_boot_st;
      boot_flag <= next_boot_flag;
    end
  end
endmodule : sdx_aux_cfg

// ### tb/sdx_aux_cfg_asserts.sv
// checker for the auxiliary configuration bank
// sees only the ports of sdx_aux_cfg; bound at the foot
module sdx_aux_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_boot_active,
  input wire logic i_card_read,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_boot_timeout,
  input wire logic o_ext_fifo_enable,
  input wire logic o_dma_req,
  input wire logic [5:0] o_active_steps,
  input wire logic [15:0] o_sample_delay_ps
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ====
  // sequences
  sequence bypass_run;
    !o_ext_fifo_enable [*4];
  endsequence
  sequence write_run;
    (o_ext_fifo_enable && !i_card_read) [*5];
  endsequence
  sequence boot_off;
    !i_boot_active [*8];
  endsequence
  // ====
  // properties
  bus_ready_a: assert property (o_hreadyout)
    else $error("bus stalled");
  bus_okay_a: assert property (!o_hresp)
    else $error("bus error response");
  fifo_bypass_a: assert property (bypass_run |-> o_dma_req)
    else $error("dma request low in bypass");
  write_dma_a: assert property (write_run |-> o_dma_req)
    else $error("dma request low on write");
  steps_max_a: assert property (o_active_steps <= 6'd40)
    else $error("step count above range");
  delay_range_a: assert property (
    $stable(o_active_steps) [*3] |->
    int'(o_sample_delay_ps) >= 200 * o_active_steps &&
    int'(o_sample_delay_ps) <= 1100 * o_active_steps)
    else $error("total delay off step count");
  timeout_cause_a: assert property (
    $rose(o_boot_timeout) |-> i_boot_active)
    else $error("timeout outside boot");
  boot_clear_a: assert property (boot_off |-> ##4 !o_boot_timeout)
    else $error("timeout kept after boot");
endmodule : sdx_aux_asserts

bind sdx_aux_cfg sdx_aux_asserts u_chk (.i_clk, .i_rst_n, .i_boot_active,
  .i_card_read, .o_hreadyout, .o_hresp, .o_boot_timeout,
  .o_ext_fifo_enable, .o_dma_req, .o_active_steps, .o_sample_delay_ps);

// ### tb/sdx_card_model.sv
// card side model: card clock and extension fifo fill level
// level walks one word per card clock toward the bench's target
module sdx_card_model (
  input wire logic [3:0] i_target,
  output logic o_card_clk,
  output logic [3:0] o_fifo_words
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_card_clk = 1'b0;
    #7;
    forever #15 o_card_clk = ~o_card_clk;
  end
  initial o_fifo_words = 4'h0;
  // card refills, dma drains, one word at a time
  always @(posedge o_card_clk) begin
    if (o_fifo_words < i_target) o_fifo_words <= o_fifo_words + 4'h1;
    else if (o_fifo_words > i_target) o_fifo_words <= o_fifo_words - 4'h1;
  end
endmodule : sdx_card_model

// ### tb/sdx_aux_cfg_tb.sv
// self-checking bench for the auxiliary configuration bank
// needs sdx_aux_cfg, its checker and the card model
module sdx_aux_cfg_tb;
  import sdx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst_n, hsel, hwrite, boot, rd_dir;
  logic [31:0] haddr, hwdata, rd_val;
  logic [1:0] htrans;
  logic [7:0] irq, wake;
  logic [3:0] target;
  wire logic card_clk, ready, resp, tmo, dbg, fen, dma;
  wire logic [3:0] words;
  wire logic [7:0] spi;
  wire logic [5:0] steps;
  wire logic [15:0] dly;
  wire logic [31:0] hrdata;
  int mismatches, tests_run;
  logic [63:0] q[$];
  event rd_ev;
  logic [31:0] v[9];
  logic [31:0] msk[9] = '{32'hffffffff, 32'h1, 32'h7, 32'h1, 32'h7,
    32'h3f, 32'h3f, 32'hff, 32'hffff0000};
  int ps[8] = '{200, 400, 400, 600, 700, 900, 900, 1100};
  sdx_card_model card (.i_target(target), .o_card_clk(card_clk),
    .o_fifo_words(words));
  sdx_aux_cfg dut (.i_clk, .i_rst_n, .i_card_clk(card_clk), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(ready),
    .o_hrdata(hrdata), .o_hreadyout(ready), .o_hresp(resp),
    .i_boot_active(boot), .i_card_read(rd_dir), .i_fifo_words(words),
    .i_slot_irq(irq), .i_slot_wakeup(wake), .o_boot_timeout(tmo),
    .o_debug_bus_select(dbg), .o_ext_fifo_enable(fen), .o_dma_req(dma),
    .o_spi_interrupt_any_select(spi), .o_active_steps(steps),
    .o_sample_delay_ps(dly));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // ====
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic hang;
    mismatches++;
    give_verdict();
  endtask : hang
  always @(rd_ev) begin : watch
    logic [63:0] me;
    me = q.pop_front();
    check(rd_val & me[63:32], me[31:0] & me[63:32]);
  end
  // ====
  // bus and wait tasks
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [63:0] me);
    int n;
    n = 0;
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge i_clk); while (ready !== 1'b1 && ++n < 50);
    if (n >= 50) hang();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge i_clk); while (ready !== 1'b1 && ++n < 99);
    if (n >= 99) hang();
    if (!w) begin
      q.push_back(me);
      rd_val = hrdata;
      ->rd_ev;
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 64'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    bus(a, 1'b0, 32'h0, {m, e});
  endtask : rd
  task automatic await(input logic sel, input logic e);
    int n;
    n = 0;
    while ((sel ? tmo : dma) !== e && n++ < 400) @(posedge i_clk);
    if (n >= 400) hang();
    check(sel ? tmo : dma, e);
  endtask : await
  initial begin
    #2000000;
    hang();
  end
  // ====
  // main sequence
  initial begin
    int s1, s2, r;
    {i_rst_n, hsel, hwrite, boot, rd_dir, htrans} = '0;
    {haddr, hwdata, irq, wake, target} = '0;
    void'($urandom(32'h93b3));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rd(8'(4 * i), '1, {24'h0, i == 10 ? 8'h4 : 8'h0});
    end
    repeat (2) for (int i = 0; i < 9; i++) begin
      v[i] = $urandom();
      if (i == 5 || i == 6) v[i] = v[i] % 41;
      wr(8'(4 * i), v[i]);
      rd(8'(4 * i), msk[i], v[i]);
    end
    check(dbg, v[1][0]);
    check(fen, v[3][0]);
    check(spi, v[7][7:0]);
    check(dma, 1'b1);
    wr(8'h2c, $urandom());
    rd(8'h2c, '1, 32'h0);
    irq <= 8'($urandom());
    wake <= 8'($urandom());
    repeat (6) @(posedge i_clk);
    rd(SDX_OFF_SLOT_VER, 32'hff, {24'h0, irq | wake});
    for (int c = 0; c < 8; c++) begin
      s1 = $urandom() % 41;
      s2 = $urandom() % 41;
      wr(SDX_OFF_STEP_DELAY, c);
      wr(SDX_OFF_STEPS_SDR, s1);
      wr(SDX_OFF_STEPS_DDR, s2);
      wr(SDX_OFF_CTRL, (c % 5) << SDX_CTRL_MODE_LSB);
      repeat (2) @(posedge i_clk);
      r = (c % 5 == 4) ? s2 : s1;
      check(steps, r);
      check(dly, r * ps[c]);
    end
    wr(SDX_OFF_STEPS_SDR, 32'h3f);
    wr(SDX_OFF_CTRL, 32'h0);
    repeat (2) @(posedge i_clk);
    check(steps, 32'h28);
    wr(SDX_OFF_FIFO_THRESH, 32'h4);
    wr(SDX_OFF_FIFO_EN, 32'h1);
    rd_dir <= 1'b1;
    await(1'b0, 1'b0);
    target <= 4'h6;
    await(1'b0, 1'b1);
    target <= 4'h3;
    await(1'b0, 1'b0);
    target <= 4'h4;
    await(1'b0, 1'b1);
    target <= 4'h0;
    await(1'b0, 1'b0);
    rd_dir <= 1'b0;
    await(1'b0, 1'b1);
    rd_dir <= 1'b1;
    await(1'b0, 1'b0);
    wr(SDX_OFF_FIFO_EN, 32'h0);
    await(1'b0, 1'b1);
    wr(SDX_OFF_BOOT_TIMEOUT, 32'h5);
    boot <= 1'b1;
    repeat (3) @(posedge i_clk);
    check(tmo, 1'b0);
    await(1'b1, 1'b1);
    boot <= 1'b0;
    await(1'b1, 1'b0);
    wr(SDX_OFF_BOOT_TIMEOUT, 32'h258);
    boot <= 1'b1;
    repeat (300) @(posedge i_clk);
    boot <= 1'b0;
    repeat (20) @(posedge i_clk);
    boot <= 1'b1;
    repeat (300) @(posedge i_clk);
    check(tmo, 1'b0);
    await(1'b1, 1'b1);
    boot <= 1'b0;
    give_verdict();
  end
endmodule : sdx_aux_cfg_tb
